/* src/audio_port_pkg.sv */
// constants shared by the first audio port companding and loopback block
// assumes a 16-bit register port and 16-bit linear samples on the user side
package audio_port_pkg;
  // register addresses, as presented on reg_addr
  localparam logic [15:0] FMT_REG_ADDR  = 16'h0300;
  localparam logic [15:0] CTRL_REG_ADDR = 16'h0301;
  localparam logic [15:0] STAT_REG_ADDR = 16'h0302;
  localparam logic [15:0] PULL_REG_ADDR = 16'h0720;
  // format register fields
  localparam int FMT_LSB        = 3;
  localparam int DSP_MODE_B_BIT = 7;
  localparam logic [1:0] FMT_RESET = 2'h2;
  // control register fields
  localparam int RX_EN_BIT   = 4;
  localparam int RX_TYPE_BIT = 3;
  localparam int TX_EN_BIT   = 2;
  localparam int TX_TYPE_BIT = 1;
  localparam int LOOP_BIT    = 0;
  // pull register: pairs of up/down for rx data, frame clock, bit clock
  localparam int PULL_BITS = 6;
  localparam logic [5:0] PULL_RESET = 6'h00;
  typedef enum logic [1:0] {
    FMT_RIGHT = 2'h0,
    FMT_LEFT  = 2'h1,
    FMT_I2S   = 2'h2,
    FMT_DSP   = 2'h3
  } port_format_t;
  // word sizes in bit clocks
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  // segmented law constants
  localparam logic [13:0] MU_CLIP     = 14'h1FDF;
  localparam logic [13:0] MU_BIAS     = 14'h0021;
  localparam logic [15:0] MU_DEC_BIAS = 16'h0084;
  localparam logic [13:0] MU_SEG_END  = 14'h003F;
  localparam logic [11:0] A_SEG_END   = 12'h01F;
  localparam logic [7:0]  A_INV_MASK  = 8'h55;
  localparam logic [15:0] A_DEC_HALF  = 16'h0008;
  localparam logic [15:0] A_DEC_BIAS  = 16'h0108;
endpackage

/* src/audio_port_companding_loopback.sv */
// first audio port data path: companding, 8-bit words, loopback, pin pulls
// assumes slave clocks from the far end, sampled by clk_sys (far faster)
`timescale 1ns/10ps
`default_nettype none
module audio_port_companding_loopback (
  // clock, reset, enable
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        clk_en,
  // register port
  input  wire logic [15:0] reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  // serial pins
  input  wire logic        bit_clock_pin,
  input  wire logic        frame_clock_pin,
  input  wire logic        rx_serial_data_pin,
  output logic             tx_serial_data_pin,
  // pin resistor controls
  output logic             rx_data_pullup,
  output logic             rx_data_pulldown,
  output logic             frame_clock_pullup,
  output logic             frame_clock_pulldown,
  output logic             bit_clock_pullup,
  output logic             bit_clock_pulldown,
  // user sample side
  input  wire logic [15:0] tx_sample,
  output logic             tx_sample_taken,
  output logic      [15:0] rx_sample,
  output logic             rx_sample_valid
);
  import audio_port_pkg::*;

  typedef struct packed {
    logic [2:0]  bclk_sync;
    logic [2:0]  frame_sync;
    logic [1:0]  rxd_sync;
    logic [1:0]  fmt;
    logic        dsp_b;
    logic        rx_en;
    logic        rx_type;
    logic        tx_en;
    logic        tx_type;
    logic        loop;
    logic [5:0]  pull;
    logic [7:0]  cnt;
    logic [7:0]  half_len;
    logic [4:0]  left;
    logic        chain;
    logic [15:0] tx_sh;
    logic [15:0] rx_sh;
    logic        txd;
    logic [15:0] rx_word;
    logic        rx_valid;
    logic        tx_taken;
    logic [15:0] rdata;
  } state_t;

  state_t q;
  state_t n;

  function automatic logic [7:0] mu_compress(input logic [15:0] s);
    logic        neg;
    logic [13:0] x;
    logic [13:0] mag;
    logic [2:0]  seg;
    x = s[15:2];
    neg = x[13];
    mag = neg ? 14'(-x) : x;
    if (mag > MU_CLIP) begin
      mag = MU_CLIP;
    end
    mag = 14'(mag + MU_BIAS);
    // the clipped top value would spill past the last segment
    if (mag[13]) begin
      mag = 14'h1FFF;
    end
    seg = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if ((mag >> (i - 1)) > MU_SEG_END) begin
        seg = 3'(i);
      end
    end
    return ~{neg, seg, 4'(mag >> (4'(seg) + 4'h1))};
  endfunction

  function automatic logic [7:0] a_compress(input logic [15:0] s);
    logic        neg;
    logic [12:0] x;
    logic [11:0] mag;
    logic [2:0]  seg;
    logic [3:0]  mant;
    x = s[15:3];
    neg = x[12];
    mag = neg ? 12'(~x) : x[11:0];
    seg = 3'h0;
    for (int i = 1; i < 8; i++) begin
      if ((mag >> (i - 1)) > A_SEG_END) begin
        seg = 3'(i);
      end
    end
    mant = (seg == 3'h0) ? mag[4:1] : 4'(mag >> seg);
    return {~neg, seg, mant} ^ A_INV_MASK;
  endfunction

  function automatic logic [15:0] mu_expand(input logic [7:0] c);
    logic [7:0]  u;
    logic [15:0] t;
    u = ~c;
    t = 16'({u[3:0], 3'h0}) + MU_DEC_BIAS;
    t = 16'(t << u[6:4]);
    return u[7] ? 16'(MU_DEC_BIAS - t) : 16'(t - MU_DEC_BIAS);
  endfunction

  function automatic logic [15:0] a_expand(input logic [7:0] c);
    logic [7:0]  a;
    logic [15:0] t;
    a = c ^ A_INV_MASK;
    t = 16'({a[3:0], 4'h0});
    if (a[6:4] == 3'h0) begin
      t = 16'(t + A_DEC_HALF);
    end else begin
      t = 16'((t + A_DEC_BIAS) << (a[6:4] - 3'h1));
    end
    return a[7] ? t : 16'(-t);
  endfunction

  logic        eight_bit;
  logic        dsp;
  logic [4:0]  wbits;
  logic        bclk_rise;
  logic        bclk_fall;
  logic        frame_evt;
  logic [7:0]  rj_len;
  logic [7:0]  start_pos;
  logic        rx_bit;
  logic [15:0] tx_word;
  logic [15:0] rx_full;
  logic        load;

  // the type bits alone also pick 8-bit words
  assign eight_bit = q.rx_en | q.tx_en | q.rx_type | q.tx_type;
  assign wbits = eight_bit ? BYTE_BITS : WORD_BITS;
  assign dsp = (q.fmt == FMT_DSP);
  assign bclk_rise = q.bclk_sync[1] & ~q.bclk_sync[2];
  assign bclk_fall = ~q.bclk_sync[1] & q.bclk_sync[2];
  // DSP frames start on the frame clock rise only, others on each edge
  assign frame_evt = dsp ? (q.frame_sync[1] & ~q.frame_sync[2])
                         : (q.frame_sync[1] ^ q.frame_sync[2]);
  assign rj_len = frame_evt ? q.cnt : q.half_len;
  // loopback ignores the external data pin entirely
  assign rx_bit = q.loop ? q.txd : q.rxd_sync[1];
  assign rx_full = {q.rx_sh[14:0], rx_bit};

  always_comb begin
    case (port_format_t'(q.fmt))
      FMT_LEFT:  start_pos = 8'h00;
      FMT_I2S:   start_pos = 8'h01;
      FMT_DSP:   start_pos = q.dsp_b ? 8'h00 : 8'h01;
      FMT_RIGHT: start_pos = (rj_len >= 8'(wbits)) ? 8'(rj_len - 8'(wbits)) : 8'h00;
      default:   start_pos = 8'h00;
    endcase
  end

  always_comb begin
    // companded or 8-bit words go out left aligned in the top byte
    if (q.tx_en) begin
      tx_word = {q.tx_type ? a_compress(tx_sample) : mu_compress(tx_sample),
                 8'h00};
    end else if (eight_bit) begin
      tx_word = {tx_sample[15:8], 8'h00};
    end else begin
      tx_word = tx_sample;
    end
  end

  always_comb begin
    n = q;
    n.bclk_sync = {q.bclk_sync[1:0], bit_clock_pin};
    n.frame_sync = {q.frame_sync[1:0], frame_clock_pin};
    n.rxd_sync = {q.rxd_sync[0], rx_serial_data_pin};
    n.rx_valid = 1'b0;
    n.tx_taken = 1'b0;
    n.rdata = 16'h0000;
    load = 1'b0;
    if (reg_wr) begin
      case (reg_addr)
        FMT_REG_ADDR: begin
          n.fmt = reg_wdata[FMT_LSB +: 2];
          n.dsp_b = reg_wdata[DSP_MODE_B_BIT];
        end
        CTRL_REG_ADDR: begin
          n.rx_en = reg_wdata[RX_EN_BIT];
          n.rx_type = reg_wdata[RX_TYPE_BIT];
          n.tx_en = reg_wdata[TX_EN_BIT];
          n.tx_type = reg_wdata[TX_TYPE_BIT];
          n.loop = reg_wdata[LOOP_BIT];
        end
        PULL_REG_ADDR: n.pull = reg_wdata[PULL_BITS-1:0];
        default: n.pull = q.pull;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        FMT_REG_ADDR: begin
          n.rdata[FMT_LSB +: 2] = q.fmt;
          n.rdata[DSP_MODE_B_BIT] = q.dsp_b;
        end
        CTRL_REG_ADDR: begin
          n.rdata[RX_EN_BIT] = q.rx_en;
          n.rdata[RX_TYPE_BIT] = q.rx_type;
          n.rdata[TX_EN_BIT] = q.tx_en;
          n.rdata[TX_TYPE_BIT] = q.tx_type;
          n.rdata[LOOP_BIT] = q.loop;
        end
        STAT_REG_ADDR: n.rdata = {14'h0000, q.left != 5'h00, eight_bit};
        PULL_REG_ADDR: n.rdata = {10'h000, q.pull};
        default: n.rdata = 16'h0000;
      endcase
    end
    if (frame_evt) begin
      // a new frame restarts the slot position and any word in flight
      n.cnt = 8'h00;
      n.half_len = q.cnt;
      n.chain = 1'b0;
      n.left = 5'h00;
      load = (start_pos == 8'h00);
    end else if (bclk_rise) begin
      if (q.cnt != 8'hFF) begin
        n.cnt = 8'(q.cnt + 8'h01);
      end
      if (q.left != 5'h00) begin
        n.rx_sh = rx_full;
        n.left = 5'(q.left - 5'h01);
        if (q.left == 5'h01) begin
          n.rx_valid = 1'b1;
          n.chain = dsp;
          if (q.rx_en) begin
            n.rx_word = q.rx_type ? a_expand(rx_full[7:0])
                                  : mu_expand(rx_full[7:0]);
          end else if (eight_bit) begin
            n.rx_word = {rx_full[7:0], 8'h00};
          end else begin
            n.rx_word = rx_full;
          end
        end
      end
    end else if (bclk_fall) begin
      if (q.left != 5'h00) begin
        n.txd = q.tx_sh[15];
        n.tx_sh = {q.tx_sh[14:0], 1'b0};
      end else if (q.chain || (q.cnt == start_pos && start_pos != 8'h00)) begin
        load = 1'b1;
      end else begin
        // unused slot time is driven low
        n.txd = 1'b0;
      end
    end
    if (load) begin
      n.txd = tx_word[15];
      n.tx_sh = {tx_word[14:0], 1'b0};
      n.left = wbits;
      n.tx_taken = 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      q <= '0;
      q.fmt <= FMT_RESET;
      q.pull <= PULL_RESET;
    end else if (clk_en) begin
      q <= n;
    end
  end

  assign reg_rdata = q.rdata;
  assign tx_serial_data_pin = q.txd;
  assign tx_sample_taken = q.tx_taken;
  assign rx_sample = q.rx_word;
  assign rx_sample_valid = q.rx_valid;
  // a pin with both resistors requested gets neither
  assign rx_data_pullup = q.pull[5] & ~q.pull[4];
  assign rx_data_pulldown = q.pull[4] & ~q.pull[5];
  assign frame_clock_pullup = q.pull[3] & ~q.pull[2];
  assign frame_clock_pulldown = q.pull[2] & ~q.pull[3];
  assign bit_clock_pullup = q.pull[1] & ~q.pull[0];
  assign bit_clock_pulldown = q.pull[0] & ~q.pull[1];
endmodule // audio_port_companding_loopback
`default_nettype wire

/* bench/audio_port_properties.sv */
// checker: register, pull-resistor and sample-pulse timing of the audio port
// assumes clk_en high whenever a property should hold
`timescale 1ns/10ps
`default_nettype none
module audio_port_properties (
  // clock and register port
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire logic        clk_en,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  // pins and samples
  input wire logic        tx_serial_data_pin,
  input wire logic        rx_data_pullup,
  input wire logic        rx_data_pulldown,
  input wire logic        frame_clock_pullup,
  input wire logic        frame_clock_pulldown,
  input wire logic        bit_clock_pullup,
  input wire logic        bit_clock_pulldown,
  input wire logic        tx_sample_taken,
  input wire logic [15:0] rx_sample,
  input wire logic        rx_sample_valid
);
  import audio_port_pkg::*;
  logic [5:0] pulls;
  assign pulls = {rx_data_pullup, rx_data_pulldown, frame_clock_pullup,
                  frame_clock_pulldown, bit_clock_pullup, bit_clock_pulldown};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_pull_wr(logic [5:0] v);
    reg_wr && clk_en && reg_addr == PULL_REG_ADDR && reg_wdata[5:0] == v;
  endsequence
  sequence s_pull_rd;
    reg_rd && clk_en && reg_addr == PULL_REG_ADDR;
  endsequence
  a_pull_map: assert property (s_pull_wr(6'h26) |=> pulls == 6'h26)
    else $error("pull outputs differ from written enables");
  a_pull_both_off: assert property (s_pull_wr(6'h3F) |=> pulls == 6'h00)
    else $error("pull applied with both enables set");
  a_pull_pairs: assert property (!(pulls[5] && pulls[4]) && !(pulls[3] && pulls[2])
    && !(pulls[1] && pulls[0])) else $error("both resistors on one pin");
  a_pull_read: assert property (s_pull_rd |=> reg_rdata[15:6] == 10'h000
    && (reg_rdata[5:4] != 2'h2 || pulls[5:4] == 2'h2)) else $error("pull read mismatch");
  a_reset_quiet: assert property ($fell(rst) |-> pulls == 6'h00
    && !tx_serial_data_pin && rx_sample == 16'h0000) else $error("outputs busy after reset");
  a_taken_gap: assert property (tx_sample_taken |=> !tx_sample_taken [*8])
    else $error("sample taken twice within one word");
  a_rx_hold: assert property ($changed(rx_sample) |-> rx_sample_valid)
    else $error("rx sample changed without valid");
  a_valid_pulse: assert property (rx_sample_valid |=> !rx_sample_valid [*8])
    else $error("rx valid repeated within one word");
endmodule // audio_port_properties
bind audio_port_companding_loopback audio_port_properties i_props (.*);
`default_nettype wire

/* bench/audio_far_end.sv */
// far-end model: drives bit clock, frame clock and rx data, captures tx data
// assumes the device is slave in DSP mode B (mode A when mode_a is set), 8-bit words
`timescale 1ns/10ps
`default_nettype none
module audio_far_end (
  // link pins
  output var logic       bit_clock_pin = 1'b0,
  output var logic       frame_clock_pin = 1'b0,
  output var logic       rx_serial_data_pin = 1'b0,
  input  wire logic      tx_serial_data_pin,
  // captured transmit byte
  output var logic [7:0] tx_got = 8'h00,
  output var logic       tx_got_stb = 1'b0
);
  logic mode_a = 1'b0;
  // two words back to back after one frame rise; clocks stand still between frames
  task automatic send(input logic [7:0] b);
    logic [7:0] cap;
    #13;
    if (mode_a) begin
      // one idle bit clock under the frame pulse ahead of the MSB
      #100 frame_clock_pin = 1'b1;
      #100 bit_clock_pin = 1'b1;
      #200 bit_clock_pin = 1'b0;
    end
    for (int w = 0; w < 2; w++) begin
      for (int i = 7; i >= 0; i--) begin
        // frame clock and data move in mid-low of the bit clock
        #100 frame_clock_pin = (w == 0 && i == 7 && !mode_a);
        rx_serial_data_pin = b[i];
        #100 bit_clock_pin = 1'b1;
        #190 cap[i] = tx_serial_data_pin;
        #10 bit_clock_pin = 1'b0;
      end
      tx_got = cap;
      tx_got_stb = 1'b1;
      #5 tx_got_stb = 1'b0;
    end
    // released line shows the inverse of its last bit, never a stale value
    rx_serial_data_pin = ~rx_serial_data_pin;
  endtask
endmodule // audio_far_end
`default_nettype wire

/* bench/audio_port_companding_loopback_test.sv */
// self-checking bench for the audio port companding and loopback block
// assumes the far-end model drives the link and the checker is bound
`timescale 1ns/10ps
`default_nettype none
module audio_port_companding_loopback_test;
  import audio_port_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst, clk_en, reg_wr, reg_rd, taken, valid, stb, bclk, fclk, rxd, txd;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, tx_sample, rx_sample;
  logic [5:0]  pulls;
  logic [7:0]  got;
  logic [31:0] seed;
  logic [55:0] tbl [8];
  logic [7:0]  tq [$];
  logic [15:0] rq [$];
  int          error_cnt = 0, n_compared = 0, cyc = 0;
  always #25 clk_sys = ~clk_sys;
  audio_port_companding_loopback i_dut (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bit_clock_pin(bclk), .frame_clock_pin(fclk),
    .rx_serial_data_pin(rxd), .tx_serial_data_pin(txd), .rx_data_pullup(pulls[5]),
    .rx_data_pulldown(pulls[4]), .frame_clock_pullup(pulls[3]),
    .frame_clock_pulldown(pulls[2]), .bit_clock_pullup(pulls[1]),
    .bit_clock_pulldown(pulls[0]), .tx_sample(tx_sample), .tx_sample_taken(taken),
    .rx_sample(rx_sample), .rx_sample_valid(valid));
  audio_far_end i_far (.bit_clock_pin(bclk), .frame_clock_pin(fclk),
    .rx_serial_data_pin(rxd), .tx_serial_data_pin(txd), .tx_got(got), .tx_got_stb(stb));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task chk(input string n, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(negedge clk_sys);
  endtask
  task rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk("reg_rdata", e, reg_rdata);
  endtask
  // one frame of two words; expected tx byte and rx sample noted per word
  task frame(input logic [7:0] c, input logic [15:0] s, input logic [7:0] rb,
             input logic [7:0] tb, input logic [15:0] rs);
    wr(CTRL_REG_ADDR, {8'h00, c});
    @(posedge clk_sys);
    tx_sample <= s;
    repeat (2) begin
      tq.push_back(tb);
      rq.push_back(rs);
    end
    i_far.send(rb);
    repeat (20) @(posedge clk_sys);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk_sys)
    if (valid === 1'b1) chk("rx_sample", rq.size() ? rq.pop_front() : 16'hXXXX, rx_sample);
  always @(posedge stb)
    chk("tx_byte", {8'h00, tq.size() ? tq.pop_front() : 8'hXX}, {8'h00, got});
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    // ctrl, tx sample, rx pin byte, tx byte, rx sample
    tbl = '{56'h14_7FFF_FF_80_0000, 56'h1E_8000_AA_2A_7E00, 56'h04_8000_D5_00_D500,
            56'h10_1234_80_12_7D7C, 56'h02_A55A_3C_A5_3C00, 56'h08_0000_C3_00_C300,
            56'h1F_0000_12_D5_0008, 56'h15_7FFF_5A_80_7D7C};
    rst = 1'b1;
    clk_en = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    tx_sample = 16'h0000;
    seed = 32'hB331;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    rd(CTRL_REG_ADDR, 16'h0000);
    rd(FMT_REG_ADDR, 16'h0010);
    wr(PULL_REG_ADDR, 16'h0026);
    chk("pulls", 16'h0026, {10'h000, pulls});
    rd(PULL_REG_ADDR, 16'h0026);
    wr(PULL_REG_ADDR, 16'h003F);
    chk("pulls", 16'h0000, {10'h000, pulls});
    wr(16'h0721, 16'hFFFF);
    rd(16'h0721, 16'h0000);
    // a write while frozen must not land
    @(posedge clk_sys);
    clk_en <= 1'b0;
    wr(PULL_REG_ADDR, 16'h0015);
    @(posedge clk_sys);
    clk_en <= 1'b1;
    rd(PULL_REG_ADDR, 16'h003F);
    rd(STAT_REG_ADDR, 16'h0000);
    wr(CTRL_REG_ADDR, 16'h0002);
    rd(STAT_REG_ADDR, 16'h0001);
    wr(FMT_REG_ADDR, 16'h0098);
    rd(FMT_REG_ADDR, 16'h0098);
    foreach (tbl[k])
      frame(tbl[k][55:48], tbl[k][47:32], tbl[k][31:24], tbl[k][23:16], tbl[k][15:0]);
    for (int k = 0; k < 4; k++) begin
      seed = xs(seed);
      frame(8'h03, seed[15:0], seed[23:16], seed[15:8], {seed[15:8], 8'h00});
    end
    wr(FMT_REG_ADDR, 16'h0018);
    i_far.mode_a = 1'b1;
    frame(8'h14, 16'h8000, 8'h80, 8'h00, 16'h7D7C);
    rd(CTRL_REG_ADDR, 16'h0014);
    repeat (100) @(posedge clk_sys);
    chk("queues", 16'h0000, 16'(tq.size() + rq.size()));
    final_report();
  end
endmodule // audio_port_companding_loopback_test
`default_nettype wire
